//--- rtl/link_ctrl_regs.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * link control set/clear block.
 * Assumes a 32-bit classic Wishbone port with byte addresses.
 */
// Summary of operation
// - Reserved link control bits always read zero
// - Cycle source select bit stays zero always
// - Master and root: cycle start each rollover
// - Master clear: received cycle starts load timer
// - Overlong cycle flag clears master enable
// - Master set ignored while overlong flag set
// - Run set: offset advances per tick, rolls
// - Run clear: ticks leave the offset as it is
// - PHY packets stored if accepted and enabled
// - PHY acceptance never gates self-ID packets
`ifndef LINK_CTRL_REGS_SVH
`define LINK_CTRL_REGS_SVH

// Byte addresses of the registers
`define LINK_CTRL_SET_ADDR 8'he0
`define LINK_CTRL_CLR_ADDR 8'he4
`define EVENT_STATUS_ADDR 8'hf0
`define EVENT_CLEAR_ADDR 8'hf4
`define EVENT_ENABLE_ADDR 8'hf8
`define CYCLE_TIME_ADDR 8'hfc

// Link control field positions
`define LC_SOURCE_BIT 22
`define LC_MASTER_BIT 21
`define LC_RUN_BIT 20
`define LC_PHYPKT_BIT 10
`define LC_SELFID_BIT 9
// Bits software may change; source select is left out on purpose
`define LC_WRITABLE_MASK 32'h0030_0600
`define LC_RESET 32'h0000_0000

// Event register field positions
`define EV_CYC_SENT_BIT 0
`define EV_CYC_RCVD_BIT 1
`define EV_PHY_DROP_BIT 2
`define EV_OVERLONG_BIT 25
`define EV_USED_MASK 32'h0200_0007
`define EV_RESET 32'h0000_0000

// Cycle timer: offset runs 0..3071, count 13 bits
`define CYCLE_OFFSET_W 12
`define CYCLE_COUNT_W 13
`define CYCLE_TIME_W 25
`define CYCLE_OFFSET_LAST 12'hbff

`endif

//--- rtl/link_ctrl_pkg.sv
/*
 * Types shared by the link control set/clear block.
 * Assumes the constants header is included by each design file.
 */
package link_ctrl_pkg;

    // Bus slave states, one-hot
    typedef enum logic [1:0] {
        WB_IDLE = 2'b01,
        WB_ACK = 2'b10
    } wb_state_t;

    // Kind of packet delivered by the PHY core
    typedef enum logic [1:0] {
        PKT_PHY = 2'h0,
        PKT_SELFID = 2'h1,
        PKT_CYCLE_START = 2'h2,
        PKT_OTHER = 2'h3
    } pkt_kind_t;

endpackage

//--- rtl/cycle_timer.sv
/*
 * Cycle timer: offset and cycle count, stepped by the 24.576 MHz tick.
 * Assumes the tick is a one-cycle pulse synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
`include "link_ctrl_regs.svh"

module cycle_timer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic load_i,
    input wire logic [`CYCLE_TIME_W-1:0] load_value_i,
    output logic [`CYCLE_TIME_W-1:0] time_o,
    output logic rollover_o
);

    // Count in the upper bits, offset in the lower bits
    logic [`CYCLE_OFFSET_W-1:0] offset;
    logic [`CYCLE_COUNT_W-1:0] count;
    logic [`CYCLE_OFFSET_W-1:0] next_offset;
    logic [`CYCLE_COUNT_W-1:0] next_count;
    logic next_rollover;

    // Next timer value
    always_comb begin
        next_offset = offset;
        next_count = count;
        next_rollover = 1'b0;
        if (load_i) begin
            // Resynchronise to a received cycle start
            next_offset = load_value_i[`CYCLE_OFFSET_W-1:0];
            next_count = load_value_i[`CYCLE_TIME_W-1:`CYCLE_OFFSET_W];
        end else if (run_i && tick_i) begin
            if (offset == `CYCLE_OFFSET_LAST) begin
                next_offset = '0;
                next_count = count + 1'b1;
                next_rollover = 1'b1;
            end else begin
                next_offset = offset + 1'b1;
            end
        end
    end

    // Register timer state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            offset <= '0;
            count <= '0;
            rollover_o <= 1'b0;
        end else begin
            offset <= next_offset;
            count <= next_count;
            rollover_o <= next_rollover;
        end
    end

    assign time_o = {count, offset};

endmodule
`default_nettype wire

//--- rtl/rx_gate.sv
/*
 * Receive gate: decides per incoming packet whether it is stored.
 * Assumes the PHY core gives one packet per valid pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "link_ctrl_regs.svh"

module rx_gate (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic valid_i,
    input wire link_ctrl_pkg::pkt_kind_t kind_i,
    input wire logic [`CYCLE_TIME_W-1:0] data_i,
    input wire logic accept_phy_packets_i,
    input wire logic accept_selfid_packets_i,
    input wire logic async_receive_enable_i,
    input wire logic cycle_master_enable_i,
    output logic phy_store_o,
    output logic phy_drop_o,
    output logic selfid_store_o,
    output logic cycle_load_o,
    output logic [`CYCLE_TIME_W-1:0] cycle_value_o
);

    logic next_phy_store;
    logic next_phy_drop;
    logic next_selfid_store;
    logic next_cycle_load;

    // Classify the packet
    always_comb begin
        next_phy_store = 1'b0;
        next_phy_drop = 1'b0;
        next_selfid_store = 1'b0;
        next_cycle_load = 1'b0;
        if (valid_i) begin
            case (kind_i)
                link_ctrl_pkg::PKT_PHY: begin
                    next_phy_store = accept_phy_packets_i &&
                        async_receive_enable_i;
                    next_phy_drop = !next_phy_store;
                end
                link_ctrl_pkg::PKT_SELFID: begin
                    next_selfid_store = accept_selfid_packets_i;
                end
                link_ctrl_pkg::PKT_CYCLE_START: begin
                    next_cycle_load = !cycle_master_enable_i;
                end
                default: begin
                    next_phy_store = 1'b0;
                end
            endcase
        end
    end

    // Register decisions with the carried time value
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phy_store_o <= 1'b0;
            phy_drop_o <= 1'b0;
            selfid_store_o <= 1'b0;
            cycle_load_o <= 1'b0;
            cycle_value_o <= '0;
        end else begin
            phy_store_o <= next_phy_store;
            phy_drop_o <= next_phy_drop;
            selfid_store_o <= next_selfid_store;
            cycle_load_o <= next_cycle_load;
            cycle_value_o <= data_i;
        end
    end

endmodule
`default_nettype wire

//--- rtl/link_control_set_clear.sv
/*
 * Link control set/clear register bank with cycle timer control,
 * receive acceptance gating, event status and interrupt output.
 * Assumes a classic Wishbone master and a PHY core that reports root
 * status, overlong cycles and received packets synchronously.
 */
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "link_ctrl_regs.svh"

module link_control_set_clear (
    // Clock and synchronous reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Wishbone slave
    input wire logic [7:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic [3:0] SEL_I,
    input wire logic WE_I,
    input wire logic STB_I,
    input wire logic CYC_I,
    // Read data and acknowledge
    output logic [31:0] DAT_O,
    output logic ACK_O,
    // Interrupt request
    output logic INT_O,
    // PHY core side
    input wire logic PHY_IS_ROOT_I,
    input wire logic OVERLONG_CYCLE_I,
    input wire logic CYCLE_TICK_I,
    input wire logic RX_VALID_I,
    input wire link_ctrl_pkg::pkt_kind_t RX_KIND_I,
    input wire logic [`CYCLE_TIME_W-1:0] RX_DATA_I,
    // Receive context status
    input wire logic ASYNC_RECEIVE_ENABLE_I,
    // Results
    output logic CYCLE_START_O,
    output logic [`CYCLE_TIME_W-1:0] CYCLE_TIME_O,
    output logic PHY_PKT_STORE_O,
    output logic SELFID_STORE_O
);

    // Bus slave state
    link_ctrl_pkg::wb_state_t state;
    link_ctrl_pkg::wb_state_t next_state;
    // Read data latched for the answer
    logic [31:0] next_dat;
    // Link control contents, writable bits only
    logic [31:0] link_ctrl;
    logic [31:0] next_link_ctrl;
    // Sticky events and their enables
    logic [31:0] ev_status;
    logic [31:0] next_ev_status;
    logic [31:0] ev_enable;
    logic [31:0] next_ev_enable;
    // Registered cycle start and interrupt
    logic next_cycle_start;
    logic next_int;

    // Decoded write strobe, valid at the acknowledging edge
    logic wr_now;
    // Write data masked by byte enables
    logic [31:0] wr_bits;
    // Field views of the control register and the overlong event flag
    logic cycle_master_enable;
    logic cycle_counter_run;
    logic accept_phy_packets;
    logic accept_selfid_packets;
    logic overlong_cycle_flag;

    // Submodule results
    logic timer_rollover;
    logic phy_drop;
    logic cycle_load;
    logic [`CYCLE_TIME_W-1:0] cycle_value;
    logic [`CYCLE_TIME_W-1:0] cycle_time;
    logic phy_store;
    logic selfid_store;

    assign cycle_master_enable = link_ctrl[`LC_MASTER_BIT];
    assign cycle_counter_run = link_ctrl[`LC_RUN_BIT];
    assign accept_phy_packets = link_ctrl[`LC_PHYPKT_BIT];
    assign accept_selfid_packets = link_ctrl[`LC_SELFID_BIT];
    assign overlong_cycle_flag = ev_status[`EV_OVERLONG_BIT];

    // Write happens only at the edge where the master sees ACK high
    assign wr_now = (state == link_ctrl_pkg::WB_ACK) && CYC_I && STB_I &&
        WE_I;

    // Expand byte enables over the write data
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            // Deselected lanes act as zeros
            wr_bits[i*8 +: 8] = SEL_I[i] ? DAT_I[i*8 +: 8] : 8'h00;
        end
    end

    // Bus slave next state and read data
    always_comb begin
        // Hold state and read data by default
        next_state = state;
        next_dat = DAT_O;
        case (state)
            link_ctrl_pkg::WB_IDLE: begin
                // New request: fetch read data and answer next cycle
                if (CYC_I && STB_I) begin
                    next_state = link_ctrl_pkg::WB_ACK;
                    case (ADR_I)
                        `LINK_CTRL_SET_ADDR,
                        `LINK_CTRL_CLR_ADDR: begin
                            next_dat = link_ctrl & `LC_WRITABLE_MASK;
                        end
                        // Sticky events as they stand
                        `EVENT_STATUS_ADDR: begin
                            next_dat = ev_status;
                        end
                        // Interrupt enables
                        `EVENT_ENABLE_ADDR: begin
                            next_dat = ev_enable;
                        end
                        // Live timer, count over offset
                        `CYCLE_TIME_ADDR: begin
                            next_dat = {7'h00, cycle_time};
                        end
                        // Unmapped and write-only read as zero
                        default: begin
                            next_dat = 32'h0000_0000;
                        end
                    endcase
                end
            end
            link_ctrl_pkg::WB_ACK: begin
                // Answer lasts one cycle
                next_state = link_ctrl_pkg::WB_IDLE;
            end
            // Illegal code: back to idle
            default: begin
                next_state = link_ctrl_pkg::WB_IDLE;
            end
        endcase
    end

    // Register bus slave state
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            // Idle, no answer, no data
            state <= link_ctrl_pkg::WB_IDLE;
            DAT_O <= 32'h0000_0000;
            ACK_O <= 1'b0;
        end else begin
            // Answer follows the slave state
            state <= next_state;
            DAT_O <= next_dat;
            ACK_O <= (next_state == link_ctrl_pkg::WB_ACK);
        end
    end

    // Link control next value
    always_comb begin
        // Contents hold unless written or an overlong cycle clears master
        next_link_ctrl = link_ctrl;
        if (wr_now && ADR_I == `LINK_CTRL_SET_ADDR) begin
            next_link_ctrl = link_ctrl | (wr_bits & `LC_WRITABLE_MASK);
            if (overlong_cycle_flag || OVERLONG_CYCLE_I) begin
                // Keep master as it was
                next_link_ctrl[`LC_MASTER_BIT] =
                    link_ctrl[`LC_MASTER_BIT];
            end
        end else if (wr_now && ADR_I == `LINK_CTRL_CLR_ADDR) begin
            next_link_ctrl = link_ctrl & ~(wr_bits & `LC_WRITABLE_MASK);
        end
        if (OVERLONG_CYCLE_I) begin
            next_link_ctrl[`LC_MASTER_BIT] = 1'b0;
        end
        next_link_ctrl[`LC_SOURCE_BIT] = 1'b0;
        next_link_ctrl = next_link_ctrl & `LC_WRITABLE_MASK;
    end

    // Register link control
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            // All fields off
            link_ctrl <= `LC_RESET;
        end else begin
            // Take the next contents
            link_ctrl <= next_link_ctrl;
        end
    end

    // Event status and enable next values
    always_comb begin
        // Hold unless written or an event
        next_ev_status = ev_status;
        next_ev_enable = ev_enable;
        // Software clear first, so a same-cycle event still lands
        if (wr_now && ADR_I == `EVENT_CLEAR_ADDR) begin
            next_ev_status = ev_status & ~wr_bits;
        end
        // Enables take the written word
        if (wr_now && ADR_I == `EVENT_ENABLE_ADDR) begin
            next_ev_enable = wr_bits & `EV_USED_MASK;
        end
        // Hardware events win over a clear
        // Overlong cycle seen
        if (OVERLONG_CYCLE_I) begin
            next_ev_status[`EV_OVERLONG_BIT] = 1'b1;
        end
        // Cycle start sent
        if (next_cycle_start) begin
            next_ev_status[`EV_CYC_SENT_BIT] = 1'b1;
        end
        // Remote cycle start taken
        if (cycle_load) begin
            next_ev_status[`EV_CYC_RCVD_BIT] = 1'b1;
        end
        // PHY packet discarded
        if (phy_drop) begin
            next_ev_status[`EV_PHY_DROP_BIT] = 1'b1;
        end
        // Keep only implemented bits
        next_ev_status = next_ev_status & `EV_USED_MASK;
    end

    // Cycle start and interrupt next values
    always_comb begin
        next_cycle_start = timer_rollover && cycle_master_enable &&
            PHY_IS_ROOT_I;
        // Level interrupt from enabled sticky bits
        next_int = |(next_ev_status & next_ev_enable);
    end

    // Register events, enables and outputs
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            // Nothing pending, nothing enabled
            ev_status <= `EV_RESET;
            ev_enable <= `EV_RESET;
            CYCLE_START_O <= 1'b0;
            INT_O <= 1'b0;
        end else begin
            // Take events, enables and outputs
            ev_status <= next_ev_status;
            ev_enable <= next_ev_enable;
            CYCLE_START_O <= next_cycle_start;
            INT_O <= next_int;
        end
    end

    // Cycle timer, loaded by accepted remote cycle starts
    cycle_timer timer_inst (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        // Run gate and tick
        .run_i(cycle_counter_run),
        .tick_i(CYCLE_TICK_I),
        // Remote cycle start load
        .load_i(cycle_load),
        .load_value_i(cycle_value),
        // Time and rollover back
        .time_o(cycle_time),
        .rollover_o(timer_rollover)
    );

    // Receive acceptance
    rx_gate gate_inst (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        // Packet from the PHY core
        .valid_i(RX_VALID_I),
        .kind_i(RX_KIND_I),
        .data_i(RX_DATA_I),
        // Acceptance controls
        .accept_phy_packets_i(accept_phy_packets),
        .accept_selfid_packets_i(accept_selfid_packets),
        .async_receive_enable_i(ASYNC_RECEIVE_ENABLE_I),
        .cycle_master_enable_i(cycle_master_enable),
        // Decisions back to the bank
        .phy_store_o(phy_store),
        .phy_drop_o(phy_drop),
        .selfid_store_o(selfid_store),
        .cycle_load_o(cycle_load),
        .cycle_value_o(cycle_value)
    );

    // Flop outputs of the submodules drive the ports directly
    // Live cycle time
    assign CYCLE_TIME_O = cycle_time;
    // Stored PHY packet pulse
    assign PHY_PKT_STORE_O = phy_store;
    // Stored self-ID pulse
    assign SELFID_STORE_O = selfid_store;

endmodule
`default_nettype wire

//--- sim/link_ctrl_monitor.sv
/* Port checker for the link control set/clear block.
   Assumes it is bound onto link_control_set_clear by the bind below. */
`timescale 1ns/1ps
`default_nettype none
`include "link_ctrl_regs.svh"
module link_ctrl_monitor (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADR_I,
    input wire logic WE_I,
    input wire logic STB_I,
    input wire logic CYC_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic PHY_IS_ROOT_I,
    input wire logic CYCLE_TICK_I,
    input wire logic RX_VALID_I,
    input wire link_ctrl_pkg::pkt_kind_t RX_KIND_I,
    input wire logic ASYNC_RECEIVE_ENABLE_I,
    input wire logic CYCLE_START_O,
    input wire logic [`CYCLE_TIME_W-1:0] CYCLE_TIME_O,
    input wire logic PHY_PKT_STORE_O,
    input wire logic SELFID_STORE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Last three packet strobes, so a timer load can be excluded
    logic [2:0] rx_hist;
    always_ff @(posedge CLK_I) begin
        rx_hist <= {rx_hist[1:0], RX_VALID_I};
    end
    // No received packet can be loading the timer
    wire logic quiet = (rx_hist == 3'h0);
    // Read answer from either link control address
    wire logic lc_rd = ACK_O && !WE_I && (ADR_I == `LINK_CTRL_SET_ADDR
        || ADR_I == `LINK_CTRL_CLR_ADDR);
    // Request taken, then a one-cycle answer
    sequence s_taken; CYC_I && STB_I && !ACK_O; endsequence
    sequence s_pulse; ACK_O ##1 !ACK_O; endsequence
    property p_ack; s_taken |=> s_pulse; endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
    property p_resv; lc_rd |-> (DAT_O & 32'hff8f_f9ff) == 32'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved bit set");
    property p_src; lc_rd |-> !DAT_O[22]; endproperty
    a_src: assert property (p_src) else $error("source bit set");
    property p_start;
        CYCLE_START_O |-> $past(PHY_IS_ROOT_I, 2)
            && CYCLE_TIME_O[11:1] == 11'h000;
    endproperty
    a_start: assert property (p_start) else $error("stray start");
    property p_step;
        quiet && $past(CYCLE_TICK_I) && !$stable(CYCLE_TIME_O) |->
            CYCLE_TIME_O[11:0] == $past(CYCLE_TIME_O[11:0]) + 12'h001
            || CYCLE_TIME_O[11:0] == 12'h000;
    endproperty
    a_step: assert property (p_step) else $error("bad timer step");
    property p_hold;
        quiet && !$past(CYCLE_TICK_I) |-> $stable(CYCLE_TIME_O);
    endproperty
    a_hold: assert property (p_hold) else $error("timer moved");
    property p_phy;
        PHY_PKT_STORE_O |-> $past(RX_VALID_I) && $past(ASYNC_RECEIVE_ENABLE_I)
            && $past(RX_KIND_I) == link_ctrl_pkg::PKT_PHY;
    endproperty
    a_phy: assert property (p_phy) else $error("bad phy store");
    property p_sid;
        SELFID_STORE_O |-> $past(RX_VALID_I)
            && $past(RX_KIND_I) == link_ctrl_pkg::PKT_SELFID;
    endproperty
    a_sid: assert property (p_sid) else $error("bad selfid store");
endmodule
bind link_control_set_clear link_ctrl_monitor link_ctrl_monitor_inst (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADR_I(ADR_I), .WE_I(WE_I),
    .STB_I(STB_I), .CYC_I(CYC_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .PHY_IS_ROOT_I(PHY_IS_ROOT_I), .CYCLE_TICK_I(CYCLE_TICK_I),
    .RX_VALID_I(RX_VALID_I), .RX_KIND_I(RX_KIND_I),
    .ASYNC_RECEIVE_ENABLE_I(ASYNC_RECEIVE_ENABLE_I),
    .CYCLE_START_O(CYCLE_START_O), .CYCLE_TIME_O(CYCLE_TIME_O),
    .PHY_PKT_STORE_O(PHY_PKT_STORE_O), .SELFID_STORE_O(SELFID_STORE_O));
`default_nettype wire

//--- sim/phy_core_model.sv
/* Behavioural PHY core: root status, tick, overlong pulse, packets.
   Assumes it shares the block's clock; the bench calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
`include "link_ctrl_regs.svh"
module phy_core_model (
    input wire logic clk_i,
    output logic root_o,
    output logic tick_o,
    output logic overlong_o,
    output logic valid_o,
    output link_ctrl_pkg::pkt_kind_t kind_o,
    output logic [`CYCLE_TIME_W-1:0] data_o
);
    // Set by the bench to run the tick
    logic ticking = 1'b0;
    // Idle levels at time zero
    initial begin
        root_o = 1'b0;
        tick_o = 1'b0;
        overlong_o = 1'b0;
        valid_o = 1'b0;
        kind_o = link_ctrl_pkg::PKT_OTHER;
        data_o = '0;
    end
    // One tick per clock, the fastest rate the link takes
    always @(posedge clk_i) begin
        tick_o <= ticking;
    end
    // One packet per strobe; lines show the inverse once released
    task automatic send(input link_ctrl_pkg::pkt_kind_t k,
                        input logic [`CYCLE_TIME_W-1:0] d);
        @(posedge clk_i);
        valid_o <= 1'b1;
        kind_o <= k;
        data_o <= d;
        @(posedge clk_i);
        valid_o <= 1'b0;
        kind_o <= link_ctrl_pkg::pkt_kind_t'(~k);
        data_o <= ~d;
    endtask
    // Overlong cycle seen on the bus, one clock wide
    task automatic overlong();
        @(posedge clk_i);
        overlong_o <= 1'b1;
        @(posedge clk_i);
        overlong_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
/* Self-checking bench for the link control set/clear block.
   Assumes the PHY core model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
`include "link_ctrl_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_total++; $display("Error %s exp %h got %h", nm, e, g); end end
module testbench;
    // Bus master and receive context drives
    logic CLK_I = 1'b0;
    logic RST_N_I = 1'b0;
    logic [7:0] ADR_I = 8'h00;
    logic [31:0] DAT_I = 32'h0;
    logic [3:0] SEL_I = 4'h0;
    logic WE_I = 1'b0;
    logic STB_I = 1'b0;
    logic CYC_I = 1'b0;
    logic ASYNC_RECEIVE_ENABLE_I = 1'b0;
    // Design outputs and PHY core lines
    logic [31:0] DAT_O;
    logic ACK_O, INT_O, CYCLE_START_O, PHY_PKT_STORE_O, SELFID_STORE_O;
    logic [`CYCLE_TIME_W-1:0] CYCLE_TIME_O, rx_data;
    logic root, ovl, tick, rx_valid;
    link_ctrl_pkg::pkt_kind_t rx_kind;
    // Tallies and scratch
    int err_total = 0;
    int total_checks = 0;
    int phy_cnt = 0;
    int sid_cnt = 0;
    int n, p0, s0;
    logic [31:0] q;
    always #50 CLK_I = ~CLK_I;
    link_control_set_clear link_control_set_clear_inst (
        .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADR_I(ADR_I), .DAT_I(DAT_I),
        .SEL_I(SEL_I), .WE_I(WE_I), .STB_I(STB_I), .CYC_I(CYC_I),
        .DAT_O(DAT_O), .ACK_O(ACK_O), .INT_O(INT_O),
        .PHY_IS_ROOT_I(root), .OVERLONG_CYCLE_I(ovl), .CYCLE_TICK_I(tick),
        .RX_VALID_I(rx_valid), .RX_KIND_I(rx_kind), .RX_DATA_I(rx_data),
        .ASYNC_RECEIVE_ENABLE_I(ASYNC_RECEIVE_ENABLE_I),
        .CYCLE_START_O(CYCLE_START_O), .CYCLE_TIME_O(CYCLE_TIME_O),
        .PHY_PKT_STORE_O(PHY_PKT_STORE_O), .SELFID_STORE_O(SELFID_STORE_O));
    phy_core_model phy_core_model_inst (.clk_i(CLK_I), .root_o(root),
        .tick_o(tick), .overlong_o(ovl), .valid_o(rx_valid),
        .kind_o(rx_kind), .data_o(rx_data));
    // Count store pulses seen
    always @(posedge CLK_I) begin
        if (PHY_PKT_STORE_O === 1'b1) phy_cnt++;
        if (SELFID_STORE_O === 1'b1) sid_cnt++;
    end
    // One classic cycle, held until ack; q takes the read data
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge CLK_I);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= d;
        SEL_I <= s;
        do begin
            @(posedge CLK_I);
            k++;
        end while (ACK_O !== 1'b1 && k < 50);
        `CHK("ack", 1'b1, ACK_O)
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0, 4'hf);
        `CHK("read", e, q)
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask
    // Prints the counts and the verdict, then stops
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog, far past the roughly 3300 cycles the tests take
    initial begin
        repeat (20000) @(posedge CLK_I);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        // Reset contents, unmapped place, byte lanes, set and clear
        rd(`LINK_CTRL_SET_ADDR, 32'h0);
        rd(8'h80, 32'h0);
        wb(1'b1, `LINK_CTRL_SET_ADDR, 32'hffff_ffff, 4'h2);
        rd(`LINK_CTRL_CLR_ADDR, 32'h0000_0600);
        wr(`LINK_CTRL_SET_ADDR, 32'hffff_ffff);
        rd(`LINK_CTRL_SET_ADDR, 32'h0030_0600);
        wr(`LINK_CTRL_CLR_ADDR, 32'h0010_0400);
        wr(`LINK_CTRL_SET_ADDR, 32'h0);
        rd(`LINK_CTRL_CLR_ADDR, 32'h0020_0200);
        $display("test access done");
        // Run clear: ticks must not move the timer
        phy_core_model_inst.ticking <= 1'b1;
        repeat (20) @(posedge CLK_I);
        rd(`CYCLE_TIME_ADDR, 32'h0);
        // Master and root: a start after 3072 ticks
        phy_core_model_inst.root_o <= 1'b1;
        wr(`LINK_CTRL_SET_ADDR, 32'h0010_0000);
        n = 0;
        while (CYCLE_START_O !== 1'b1 && n < 4000) begin
            @(posedge CLK_I);
            n++;
        end
        phy_core_model_inst.ticking <= 1'b0;
        `CHK("span", 1'b1, n > 3070)
        `CHK("count", 13'h1, CYCLE_TIME_O[24:12])
        $display("test timer done");
        // Overlong cycle drops master and locks it out
        wr(`EVENT_ENABLE_ADDR, 32'h0200_0000);
        rd(`EVENT_ENABLE_ADDR, 32'h0200_0000);
        phy_core_model_inst.overlong();
        repeat (2) @(posedge CLK_I);
        `CHK("irq", 1'b1, INT_O)
        rd(`LINK_CTRL_SET_ADDR, 32'h0010_0200);
        rd(`EVENT_STATUS_ADDR, 32'h0200_0001);
        wr(`LINK_CTRL_SET_ADDR, 32'h0020_0000);
        rd(`LINK_CTRL_SET_ADDR, 32'h0010_0200);
        wr(`EVENT_ENABLE_ADDR, 32'h0);
        repeat (2) @(posedge CLK_I);
        `CHK("mask", 1'b0, INT_O)
        wr(`EVENT_ENABLE_ADDR, 32'h0200_0000);
        wr(`EVENT_CLEAR_ADDR, 32'h0200_0001);
        wr(`EVENT_STATUS_ADDR, 32'hffff_ffff);
        repeat (2) @(posedge CLK_I);
        `CHK("clear", 1'b0, INT_O)
        wr(`LINK_CTRL_SET_ADDR, 32'h0020_0000);
        rd(`LINK_CTRL_SET_ADDR, 32'h0030_0200);
        $display("test overlong done");
        // Received cycle start loads the timer only with master clear
        wr(`LINK_CTRL_CLR_ADDR, 32'h0020_0000);
        phy_core_model_inst.send(link_ctrl_pkg::PKT_CYCLE_START,
                                 25'h12_3456);
        repeat (3) @(posedge CLK_I);
        `CHK("load", 25'h12_3456, CYCLE_TIME_O)
        wr(`LINK_CTRL_SET_ADDR, 32'h0020_0000);
        phy_core_model_inst.send(link_ctrl_pkg::PKT_CYCLE_START,
                                 25'h00_0777);
        repeat (3) @(posedge CLK_I);
        `CHK("noload", 25'h12_3456, CYCLE_TIME_O)
        rd(`EVENT_STATUS_ADDR, 32'h0000_0002);
        $display("test sync done");
        // Every acceptance setting against PHY, self-ID and other packets
        for (int i = 0; i < 8; i++) begin
            wr(`LINK_CTRL_CLR_ADDR, 32'h0000_0600);
            wr(`LINK_CTRL_SET_ADDR, {21'h0, i[0], i[2], 9'h0});
            ASYNC_RECEIVE_ENABLE_I <= i[1];
            p0 = phy_cnt;
            s0 = sid_cnt;
            phy_core_model_inst.send(link_ctrl_pkg::PKT_PHY, 25'h0);
            phy_core_model_inst.send(link_ctrl_pkg::PKT_SELFID, 25'h0);
            phy_core_model_inst.send(link_ctrl_pkg::PKT_OTHER, 25'h0);
            repeat (3) @(posedge CLK_I);
            `CHK("phy", i[0] & i[1], phy_cnt - p0 == 1)
            `CHK("selfid", i[2], sid_cnt - s0 == 1)
        end
        rd(`EVENT_STATUS_ADDR, 32'h0000_0006);
        $display("test receive done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
